// ### hdl/rbr_recorder.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rbr_defines.svh"
// Summary of operation
// - tag enabled: overrange goes to bit 15
// - software switch for overrange tagging
// - bit is 1 out of range, else 0
// - overrange taken fresh for every sample
// - per channel 50 ohm select, 1=50 ohm
// - auto offset write starts compensation, 0=all
// - store write saves active set to number
// - store read returns last saved set
// - recall write loads numbered set to active
// - recall read returns last loaded set
// - factory set 0 never overwritten by store while user sets exist
// - set 1 valid for store and recall
// - without user sets factory set is writable
// - factory set active after reset
// - samples taken at fixed equidistant intervals
// - samples kept in memory for later readout
// - region written as ring until trigger
// - exactly posttrigger samples after trigger, then stop
// - trigger disarmed until pretrigger filled
// - host readout only after recording finished
// - record length programmable read/write register
// - pretrigger is length minus posttrigger
module rbr_recorder #(
    parameter int MEM_AW = 10,
    parameter int SAMPLE_DIV = 4,
    parameter int CAL_SETS = 2,
    parameter int CAL_W = 32,
    parameter logic [CAL_W-1:0] FACTORY_CAL = 32'h00000000
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // avalon-mm slave
    input wire logic [19:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // converter and trigger pins
    input wire logic [11:0] adc_data_in,
    input wire logic adc_overrange_in,
    input wire logic trigger_in,
    // front end controls
    output logic [3:0] low_impedance_select_out,
    output logic auto_offset_command_out,
    output logic [31:0] auto_offset_ranges_out,
    output logic [CAL_W-1:0] cal_active_out,
    output logic recording_out
);

    // LW holds a length up to the full ring, one bit above the pointer
    localparam int LW = MEM_AW + 1;
    localparam int SW = $clog2(CAL_SETS);
    localparam int DW = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;

    // register words sit on 32-bit boundaries, so the two low address bits are zero
    function automatic logic hit(input logic [19:0] a, input logic [17:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    // fill, armed and post are the states in which the ring is being written
    function automatic logic is_running(input rbr_pkg::rbr_state_t st);
        is_running = (st == rbr_pkg::RBR_FILL) || (st == rbr_pkg::RBR_ARMED)
            || (st == rbr_pkg::RBR_POST);
    endfunction

    // single-bit control registers read back in bit 0, upper bits zero
    function automatic logic [31:0] bit_word(input logic b);
        bit_word = {31'h0, b};
    endfunction

    // bus handshake
    // every transfer takes one wait state: ack rises on the first cycle of a
    // request and drops again after one cycle, so a master that holds its request
    // sees waitrequest low exactly one cycle later
    logic ack;
    logic req;
    logic wr_go;
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack;
    assign wr_go = avs_write_in & ack;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // pin synchronisers
    // nothing but the second stage reads the first one
    logic [13:0] pin_s1;
    logic [13:0] pin_s2;
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pin_s1 <= 14'h0000;
            pin_s2 <= 14'h0000;
        end else begin
            pin_s1 <= {trigger_in, adc_overrange_in, adc_data_in};
            pin_s2 <= pin_s1;
        end
    end

    // control registers
    // unmapped writes fall through the chain and are ignored
    // termination and tag registers keep bit 0 only
    logic tag_en;
    logic [31:0] rec_len;
    logic [31:0] after_cnt;
    logic [MEM_AW-1:0] rd_addr;
    logic cmd_start;
    logic cmd_stop;

    assign cmd_start = wr_go & hit(avs_address_in, `RBR_IDX_COMMAND)
        & avs_writedata_in[`RBR_CMD_START_BIT];
    // stop is decoded apart from start so a write with both bits set stops
    assign cmd_stop = wr_go & hit(avs_address_in, `RBR_IDX_COMMAND)
        & avs_writedata_in[`RBR_CMD_STOP_BIT];

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            tag_en <= 1'b0;
            rec_len <= `RBR_RST_REC_LEN;
            after_cnt <= `RBR_RST_AFTER_CNT;
            rd_addr <= '0;
            low_impedance_select_out <= 4'h0;
        end else if (wr_go) begin
            if (hit(avs_address_in, `RBR_IDX_OVR_TAG)) begin
                tag_en <= avs_writedata_in[0];
            end else if (hit(avs_address_in, `RBR_IDX_REC_LEN)) begin
                rec_len <= avs_writedata_in;
            end else if (hit(avs_address_in, `RBR_IDX_AFTER_CNT)) begin
                after_cnt <= avs_writedata_in;
            end else if (hit(avs_address_in, `RBR_IDX_RD_ADDR)) begin
                rd_addr <= avs_writedata_in[MEM_AW-1:0];
            end else if (hit(avs_address_in, `RBR_IDX_TERM0)) begin
                low_impedance_select_out[0] <= avs_writedata_in[0];
            end else if (hit(avs_address_in, `RBR_IDX_TERM1)) begin
                low_impedance_select_out[1] <= avs_writedata_in[0];
            end else if (hit(avs_address_in, `RBR_IDX_TERM2)) begin
                low_impedance_select_out[2] <= avs_writedata_in[0];
            end else if (hit(avs_address_in, `RBR_IDX_TERM3)) begin
                low_impedance_select_out[3] <= avs_writedata_in[0];
            end
        end
    end

    // auto offset: one-cycle start pulse with the range selector held
    // the range word stays after the pulse so the front end may read it late
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            auto_offset_command_out <= 1'b0;
            auto_offset_ranges_out <= 32'h00000000;
        end else begin
            auto_offset_command_out <= 1'b0;
            if (wr_go && hit(avs_address_in, `RBR_IDX_AUTO_ADJ)) begin
                auto_offset_command_out <= 1'b1;
                auto_offset_ranges_out <= avs_writedata_in;
            end
        end
    end

    // calibration sets; only the factory slot is forced at reset so user
    // sets survive a reset the way the nonvolatile store would
    // a store to an absent set or, while user sets exist, to the factory slot leaves last_saved alone,
    // so software can read back whether its store was taken
    // user slots hold no value until first stored; recalling one early
    // loads an unknown word
    logic [CAL_W-1:0] cal_mem [CAL_SETS];
    logic [31:0] last_saved;
    logic [31:0] last_loaded;
    logic cal_wr;
    logic cal_rd;
    logic set_ok;
    logic [SW-1:0] set_idx;

    assign set_idx = avs_writedata_in[SW-1:0];
    assign set_ok = (avs_writedata_in < 32'(CAL_SETS));
    assign cal_wr = wr_go & hit(avs_address_in, `RBR_IDX_CAL_STORE) & set_ok
        & ((avs_writedata_in[7:0] != `RBR_SET_FACTORY) || (CAL_SETS == 1));
    assign cal_rd = wr_go & hit(avs_address_in, `RBR_IDX_CAL_RECALL) & set_ok;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cal_mem[0] <= FACTORY_CAL;
        end else if (cal_wr) begin
            cal_mem[set_idx] <= cal_active_out;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            last_saved <= 32'h00000000;
        end else if (cal_wr) begin
            last_saved <= avs_writedata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cal_active_out <= FACTORY_CAL;
            last_loaded <= 32'h00000000;
        end else if (cal_rd) begin
            cal_active_out <= cal_mem[set_idx];
            last_loaded <= avs_writedata_in;
        end
    end

    // sample pacing: free-running divider, no bus dependence
    // the divider never stops, so sample spacing is fixed even while the bus
    // is busy; a start only changes which tick is the first one stored
    logic [DW-1:0] div_cnt;
    logic tick;
    assign tick = (div_cnt == DW'(SAMPLE_DIV - 1));
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // trigger level as seen at the previous sample tick; comparing at ticks
    // catches an edge that lands between two ticks; a trigger pulse shorter
    // than one sample period may still be missed
    logic trig_prev;
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            trig_prev <= 1'b0;
        end else if (tick) begin
            trig_prev <= pin_s2[13];
        end
    end

    // sample word formatting
    // tag off keeps the sign in bit 15 so the word reads as a plain number
    logic [15:0] word;
    always_comb begin
        word = {{4{pin_s2[11]}}, pin_s2[11:0]};
        if (tag_en) begin
            word[`RBR_TAG_BIT] = pin_s2[12];
        end
    end

    // recorder state
    rbr_pkg::rbr_state_t state;
    logic [MEM_AW-1:0] wr_ptr;
    logic [MEM_AW-1:0] trig_pos;
    logic [LW-1:0] fill_cnt;
    logic [LW-1:0] post_cnt;
    logic [LW-1:0] len_w;
    logic [LW-1:0] post_w;
    logic [LW-1:0] pre_w;
    logic [MEM_AW-1:0] next_ptr;
    logic storing;
    logic trig_edge;

    // a zero length would leave the ring without a slot, so it counts as one;
    // a post count beyond the length is clamped so the pretrigger never goes
    // negative
    assign len_w = (rec_len == 32'h0) ? LW'(1) : rec_len[LW-1:0];
    assign post_w = (after_cnt > 32'(len_w)) ? len_w : after_cnt[LW-1:0];
    assign pre_w = len_w - post_w;
    assign next_ptr = (32'(wr_ptr) + 1 >= 32'(len_w)) ? '0 : wr_ptr + 1'b1;
    assign storing = tick && is_running(state);
    assign trig_edge = pin_s2[13] & ~trig_prev;
    assign recording_out = is_running(state);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state <= rbr_pkg::RBR_IDLE;
            wr_ptr <= '0;
            fill_cnt <= '0;
            post_cnt <= '0;
            trig_pos <= '0;
        // stop outranks start, start outranks a tick
        end else if (cmd_stop) begin
            state <= rbr_pkg::RBR_DONE;
        end else if (cmd_start) begin
            wr_ptr <= '0;
            fill_cnt <= '0;
            state <= (pre_w == '0) ? rbr_pkg::RBR_ARMED : rbr_pkg::RBR_FILL;
        end else if (storing) begin
            if (!(state == rbr_pkg::RBR_ARMED && trig_edge)) begin
                wr_ptr <= next_ptr;
            end
            case (state)
                rbr_pkg::RBR_FILL: begin
                    fill_cnt <= fill_cnt + 1'b1;
                    if (fill_cnt + 1'b1 >= pre_w) begin
                        state <= rbr_pkg::RBR_ARMED;
                    end
                end
                rbr_pkg::RBR_ARMED: begin
                    if (trig_edge) begin
                        trig_pos <= wr_ptr;
                        post_cnt <= post_w;
                        state <= (post_w == '0) ? rbr_pkg::RBR_DONE : rbr_pkg::RBR_POST;
                    end
                end
                rbr_pkg::RBR_POST: begin
                    post_cnt <= post_cnt - 1'b1;
                    if (post_cnt == LW'(1)) begin
                        state <= rbr_pkg::RBR_DONE;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // the sample seen with the trigger edge is not stored, so the post count
    // covers exactly the samples after the event; the pointer holds on that
    // tick, so trig_pos names the first post slot
    // no reset on the sample store: it is read only after a run
    logic [15:0] sample_mem [2**MEM_AW];
    logic do_write;
    assign do_write = storing && !(state == rbr_pkg::RBR_ARMED && trig_edge);

    always_ff @(posedge clk_sys_in) begin
        if (do_write) begin
            sample_mem[wr_ptr] <= word;
        end
    end

    // read path; sample memory reads zero while recording
    // readdata loads on the first cycle of a read and then holds, so it
    // stands at the edge where waitrequest is low and until the next read
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !ack) begin
            if (hit(avs_address_in, `RBR_IDX_OVR_TAG)) begin
                avs_readdata_out <= bit_word(tag_en);
            end else if (hit(avs_address_in, `RBR_IDX_REC_LEN)) begin
                avs_readdata_out <= rec_len;
            end else if (hit(avs_address_in, `RBR_IDX_AFTER_CNT)) begin
                avs_readdata_out <= after_cnt;
            end else if (hit(avs_address_in, `RBR_IDX_TERM0)) begin
                avs_readdata_out <= bit_word(low_impedance_select_out[0]);
            end else if (hit(avs_address_in, `RBR_IDX_TERM1)) begin
                avs_readdata_out <= bit_word(low_impedance_select_out[1]);
            end else if (hit(avs_address_in, `RBR_IDX_TERM2)) begin
                avs_readdata_out <= bit_word(low_impedance_select_out[2]);
            end else if (hit(avs_address_in, `RBR_IDX_TERM3)) begin
                avs_readdata_out <= bit_word(low_impedance_select_out[3]);
            end else if (hit(avs_address_in, `RBR_IDX_CAL_STORE)) begin
                avs_readdata_out <= last_saved;
            end else if (hit(avs_address_in, `RBR_IDX_CAL_RECALL)) begin
                avs_readdata_out <= last_loaded;
            end else if (hit(avs_address_in, `RBR_IDX_STATUS)) begin
                avs_readdata_out <= 32'({wr_ptr, state});
            end else if (hit(avs_address_in, `RBR_IDX_RD_ADDR)) begin
                avs_readdata_out <= 32'(rd_addr);
            end else if (hit(avs_address_in, `RBR_IDX_TRIG_POS)) begin
                avs_readdata_out <= 32'(trig_pos);
            end else if (hit(avs_address_in, `RBR_IDX_RD_DATA) && !recording_out) begin
                avs_readdata_out <= {16'h0, sample_mem[rd_addr]};
            end else begin
                avs_readdata_out <= 32'h00000000;
            end
        end
    end

endmodule

// ### hdl/rbr_defines.svh
`ifndef RBR_DEFINES_SVH
`define RBR_DEFINES_SVH

// register indices; byte address is four times the index
`define RBR_IDX_TERM0 18'h0754e
`define RBR_IDX_TERM1 18'h075b2
`define RBR_IDX_TERM2 18'h07616
`define RBR_IDX_TERM3 18'h0767a
`define RBR_IDX_CAL_STORE 18'h0c35a
`define RBR_IDX_AUTO_ADJ 18'h0c364
`define RBR_IDX_OVR_TAG 18'h31128
`define RBR_IDX_CAL_RECALL 18'h0c35b
`define RBR_IDX_REC_LEN 18'h02710
`define RBR_IDX_AFTER_CNT 18'h02774
`define RBR_IDX_COMMAND 18'h00000
`define RBR_IDX_STATUS 18'h00001
`define RBR_IDX_RD_ADDR 18'h00002
`define RBR_IDX_RD_DATA 18'h00003
`define RBR_IDX_TRIG_POS 18'h00004

// command register bits
`define RBR_CMD_START_BIT 0
`define RBR_CMD_STOP_BIT 1

// sample word layout
`define RBR_TAG_BIT 15
`define RBR_SAMPLE_W 12

// calibration set numbers
`define RBR_SET_FACTORY 8'h00
`define RBR_SET_USER0 8'h01

// reset values
`define RBR_RST_REC_LEN 32'h00000400
`define RBR_RST_AFTER_CNT 32'h00000200
`define RBR_RST_CAL_WORD 32'h00000000

`endif

// ### hdl/rbr_pkg.sv
package rbr_pkg;

    // gray code along idle -> fill -> armed -> post -> done
    typedef enum logic [2:0] {
        RBR_IDLE = 3'b000,
        RBR_FILL = 3'b001,
        RBR_ARMED = 3'b011,
        RBR_POST = 3'b010,
        RBR_DONE = 3'b110
    } rbr_state_t;

endpackage

// ### sim/rbr_front_model.sv
`timescale 1ns/1ps
module rbr_front_model (
    // clock
    input wire logic clk_sys_in,
    // levels set by the bench
    input wire logic [11:0] level_in,
    input wire logic over_in,
    input wire logic fire_in,
    // converter and trigger pins
    output logic [11:0] adc_data_out,
    output logic adc_overrange_out,
    output logic trigger_out
);
    initial begin
        adc_data_out = 12'h000;
        adc_overrange_out = 1'b0;
        trigger_out = 1'b0;
    end
    // outputs step only on a clock edge so the sync flops never see a glitch
    always @(posedge clk_sys_in) begin
        adc_data_out <= level_in;
        adc_overrange_out <= over_in;
        trigger_out <= fire_in;
    end
endmodule

// ### sim/rbr_recorder_monitor.sv
`timescale 1ns/1ps
`include "rbr_defines.svh"
module rbr_recorder_monitor #(
    parameter int CAL_W = 32,
    parameter logic [CAL_W-1:0] FACTORY_CAL = 32'h00000000
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // bus
    input wire logic [19:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // front end
    input wire logic [3:0] low_impedance_select_out,
    input wire logic auto_offset_command_out,
    input wire logic [31:0] auto_offset_ranges_out,
    input wire logic [CAL_W-1:0] cal_active_out,
    input wire logic recording_out
);
    localparam logic [19:0] A_TERM0 = {`RBR_IDX_TERM0, 2'b00};
    localparam logic [19:0] A_AUTO = {`RBR_IDX_AUTO_ADJ, 2'b00};
    localparam logic [19:0] A_CMD = {`RBR_IDX_COMMAND, 2'b00};
    logic req;
    logic wr_done;
    assign req = avs_read_in | avs_write_in;
    assign wr_done = avs_write_in & ~avs_waitrequest_out;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
        else $error("waitrequest low on first request cycle");
    chk_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest held beyond one cycle");
    chk_idle_no_wait: assert property (!req |-> !avs_waitrequest_out)
        else $error("waitrequest high with no request");
    chk_read_hold: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
        else $error("read data changed outside a read");
    chk_term_write: assert property (
        wr_done && avs_address_in == A_TERM0 |=> low_impedance_select_out[0] == $past(avs_writedata_in[0]))
        else $error("termination select not updated");
    chk_auto_pulse: assert property (
        wr_done && avs_address_in == A_AUTO |=> auto_offset_command_out
        && auto_offset_ranges_out == $past(avs_writedata_in) ##1 !auto_offset_command_out)
        else $error("auto offset pulse wrong");
    chk_factory_boot: assert property ($rose(resetn_in) |-> cal_active_out == FACTORY_CAL)
        else $error("factory set not active after reset");
    chk_start_rec: assert property (
        wr_done && avs_address_in == A_CMD && avs_writedata_in[1:0] == 2'b01 |=> recording_out)
        else $error("start did not begin recording");
    chk_stop_rec: assert property (wr_done && avs_address_in == A_CMD && avs_writedata_in[1] |=> !recording_out)
        else $error("stop did not end recording");

    cover property (wr_done && avs_address_in == A_CMD && avs_writedata_in[0]);
    cover property ($fell(recording_out));
    cover property (auto_offset_command_out);
endmodule

bind rbr_recorder rbr_recorder_monitor #(.CAL_W(CAL_W), .FACTORY_CAL(FACTORY_CAL)) i_mon (
    .clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .low_impedance_select_out, .auto_offset_command_out,
    .auto_offset_ranges_out, .cal_active_out, .recording_out);

// ### sim/rbr_recorder_bench.sv
`timescale 1ns/1ps
`include "rbr_defines.svh"
module rbr_recorder_bench;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [19:0] avs_address_in = 20'h00000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [11:0] adc_data_in;
    logic [11:0] level = 12'h000;
    logic adc_overrange_in;
    logic trigger_in;
    logic over = 1'b0;
    logic fire = 1'b0;
    logic [3:0] low_impedance_select_out;
    logic auto_offset_command_out;
    logic [31:0] auto_offset_ranges_out;
    logic [31:0] cal_active_out;
    logic recording_out;
    logic [31:0] q;
    logic [31:0] s;
    logic [17:0] term_idx [4] = '{`RBR_IDX_TERM0, `RBR_IDX_TERM1, `RBR_IDX_TERM2, `RBR_IDX_TERM3};
    int num_errors = 0;
    int n_compared = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    rbr_recorder #(.SAMPLE_DIV(2)) i_dut (.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .adc_data_in,
        .adc_overrange_in, .trigger_in, .low_impedance_select_out, .auto_offset_command_out,
        .auto_offset_ranges_out, .cal_active_out, .recording_out);
    rbr_front_model i_front (.clk_sys_in, .level_in(level), .over_in(over), .fire_in(fire),
        .adc_data_out(adc_data_in), .adc_overrange_out(adc_overrange_in), .trigger_out(trigger_in));

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // holds the request until waitrequest is sampled low; read data taken at that edge
    task automatic xfer(input logic w, input logic [17:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= d;
        @(posedge clk_sys_in);
        while (avs_waitrequest_out !== 1'b0 && n < 20) begin
            @(posedge clk_sys_in);
            n++;
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n == 20)
            cmp("bus answer", 32'h0, 32'h1);
    endtask

    task automatic rd(input string name, input logic [17:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        cmp(name, exp, q);
    endtask

    task automatic run(input logic tag, input logic [11:0] d, input logic o, input logic [15:0] exp);
        xfer(1'b1, `RBR_IDX_OVR_TAG, {31'h0, tag});
        rd("tag enable", `RBR_IDX_OVR_TAG, {31'h0, tag});
        level <= d;
        over <= o;
        xfer(1'b1, `RBR_IDX_COMMAND, 32'h1);
        fire <= 1'b1;
        repeat (30) @(posedge clk_sys_in);
        xfer(1'b0, `RBR_IDX_STATUS, 32'h0);
        cmp("armed state", 32'h3, {29'h0, q[2:0]});
        rd("data while busy", `RBR_IDX_RD_DATA, 32'h0);
        fire <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        fire <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        fire <= 1'b0;
        for (int i = 0; i < 100 && q[2:0] !== 3'b110; i++)
            xfer(1'b0, `RBR_IDX_STATUS, 32'h0);
        s = q;
        cmp("done state", 32'h6, {29'h0, s[2:0]});
        xfer(1'b0, `RBR_IDX_TRIG_POS, 32'h0);
        cmp("write pointer", (q + 32'h3) & 32'h7, {22'h0, s[12:3]});
        xfer(1'b1, `RBR_IDX_RD_ADDR, q);
        xfer(1'b0, `RBR_IDX_RD_DATA, 32'h0);
        cmp("sample word", {16'h0, exp}, {16'h0, q[15:0]});
        $display("test record %h done", exp);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(negedge clk_sys_in);
        cmp("active set", 32'h0, cal_active_out);
        cmp("termination", 32'h0, {28'h0, low_impedance_select_out});
        rd("record length", `RBR_IDX_REC_LEN, `RBR_RST_REC_LEN);
        rd("after count", `RBR_IDX_AFTER_CNT, `RBR_RST_AFTER_CNT);
        rd("unmapped", 18'h00100, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, term_idx[c], 32'h1);
            @(negedge clk_sys_in);
            cmp("termination", (32'h2 << c) - 32'h1, {28'h0, low_impedance_select_out});
            rd("termination readback", term_idx[c], 32'h1);
        end
        xfer(1'b1, `RBR_IDX_TERM0, 32'h0);
        @(negedge clk_sys_in);
        cmp("termination", 32'he, {28'h0, low_impedance_select_out});
        $display("test termination done");
        for (int v = 0; v < 6; v += 5) begin
            xfer(1'b1, `RBR_IDX_AUTO_ADJ, v);
            @(negedge clk_sys_in);
            cmp("offset ranges", v, auto_offset_ranges_out);
            cmp("offset pulse", 32'h1, {31'h0, auto_offset_command_out});
        end
        $display("test offset done");
        xfer(1'b1, `RBR_IDX_CAL_STORE, 32'h1);
        rd("last stored", `RBR_IDX_CAL_STORE, 32'h1);
        xfer(1'b1, `RBR_IDX_CAL_STORE, 32'h0);
        rd("last stored", `RBR_IDX_CAL_STORE, 32'h1);
        xfer(1'b1, `RBR_IDX_CAL_RECALL, 32'h1);
        rd("last loaded", `RBR_IDX_CAL_RECALL, 32'h1);
        @(negedge clk_sys_in);
        cmp("active set", 32'h0, cal_active_out);
        xfer(1'b1, `RBR_IDX_CAL_RECALL, 32'h0);
        rd("last loaded", `RBR_IDX_CAL_RECALL, 32'h0);
        $display("test calibration done");
        xfer(1'b1, `RBR_IDX_REC_LEN, 32'h8);
        xfer(1'b1, `RBR_IDX_AFTER_CNT, 32'h3);
        rd("record length", `RBR_IDX_REC_LEN, 32'h8);
        run(1'b1, 12'h123, 1'b1, 16'h8123);
        run(1'b0, 12'h123, 1'b1, 16'h0123);
        run(1'b1, 12'h801, 1'b0, 16'h7801);
        xfer(1'b1, `RBR_IDX_COMMAND, 32'h1);
        xfer(1'b1, `RBR_IDX_COMMAND, 32'h3);
        xfer(1'b0, `RBR_IDX_STATUS, 32'h0);
        cmp("stopped state", 32'h6, {29'h0, q[2:0]});
        $display("test stop done");
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        num_errors++;
        print_verdict;
    end
endmodule
